/* File: src/emg_edge_unit.v */
`timescale 1ns/1ps
`include "emg_map.vh"
// How it works
// - twelve select codes pick element size, endian order and flag update.
// - mask sits in low bits: 8, 4 or 2 bits wide.
// - left mask from first source low three bits, right from second.
// - 64-bit addressing, upper 61 bits equal: result is left AND right.
// - 32-bit addressing, bits 31:3 equal: result is left AND right.
// - otherwise the result is the left mask alone.
// - flag variants set condition codes as first minus second subtraction.
// - no-flag variants keep condition codes unchanged.
// - big-endian bytes: left is all ones shifted right, right fills from top.
// - big-endian halfwords use address bits 2:1, bit 0 ignored.
// - big-endian words use only address bit 2.
// - little-endian masks are the bit reversal of big-endian masks.
module emg_edge_unit #(
   parameter DATA_W = `EMG_DATA_W,
   parameter MASK_W = `EMG_MASK_W,
   parameter OPF_W  = `EMG_OPF_W,
   parameter IDX_W  = `EMG_IDX_W,
   parameter CC_W   = `EMG_CC_W
) (
   input  wire              clk,
   input  wire              resetn,
   input  wire              issue_valid,
   input  wire [OPF_W-1:0]  opf,
   input  wire              address_mask_bit,
   input  wire [DATA_W-1:0] first_source_register,
   input  wire [DATA_W-1:0] second_source_register,
   output reg               result_valid,
   output reg  [DATA_W-1:0] result,
   output reg               cc_write,
   output reg  [CC_W-1:0]   icc,
   output reg  [CC_W-1:0]   xcc,
   output reg               op_illegal
);
   // ----------------------------------------
   // local widths
   // ----------------------------------------
   localparam UPPER_W = DATA_W - MASK_W;
   localparam AM_W    = `EMG_AM_HI + 1;
   localparam SIDES   = 2;

   // ----------------------------------------
   // decode functions
   // ----------------------------------------
   // codes above the last one are flagged, never executed, so no trap is needed
   function f_known;
      input [OPF_W-1:0] op;
      begin
         f_known = (op <= `EMG_OPF_LAST);
      end
   endfunction

   function [1:0] f_size;
      input [OPF_W-1:0] op;
      begin
         f_size = op[`EMG_OPF_SIZE_HI:`EMG_OPF_SIZE_LO];
      end
   endfunction

   function f_little;
      input [OPF_W-1:0] op;
      begin
         f_little = op[`EMG_OPF_LITTLE];
      end
   endfunction

   function f_flag_write;
      input [OPF_W-1:0] op;
      begin
         f_flag_write = f_known(op) & ~op[`EMG_OPF_NOFLAGS];
      end
   endfunction

   // packs one flag nibble in n z v c order
   function [CC_W-1:0] f_cc;
      input n;
      input z;
      input v;
      input c;
      begin
         f_cc = 4'h0;
         f_cc[`EMG_CC_N] = n;
         f_cc[`EMG_CC_Z] = z;
         f_cc[`EMG_CC_V] = v;
         f_cc[`EMG_CC_C] = c;
      end
   endfunction

   // ----------------------------------------
   // decode
   // ----------------------------------------
   wire       known   = f_known(opf);
   wire [1:0] size    = f_size(opf);
   wire       little  = f_little(opf);
   wire       flag_op = f_flag_write(opf);

   // ----------------------------------------
   // left and right edge masks
   // ----------------------------------------
   // side 0 reads the first operand, side 1 the second
   wire [SIDES*IDX_W-1:0]  idx_pair;
   wire [SIDES*MASK_W-1:0] mask_pair;
   assign idx_pair = {second_source_register[`EMG_IDX_HI:0],
                      first_source_register[`EMG_IDX_HI:0]};

   genvar g;
   generate
      for (g = 0; g < SIDES; g = g + 1) begin : g_side
         emg_mask_lut u_lut (
            .size   (size),
            .little (little),
            .right  (g == 1),
            .idx    (idx_pair[g*IDX_W +: IDX_W]),
            .mask   (mask_pair[g*MASK_W +: MASK_W])
         );
      end
   endgenerate

   wire [MASK_W-1:0] lmask = mask_pair[0 +: MASK_W];
   wire [MASK_W-1:0] rmask = mask_pair[MASK_W +: MASK_W];

   // ----------------------------------------
   // block compare and merge
   // ----------------------------------------
   wire same64 = first_source_register[DATA_W-1:`EMG_BLK_LO] ==
                 second_source_register[DATA_W-1:`EMG_BLK_LO];
   wire same32 = first_source_register[`EMG_AM_HI:`EMG_BLK_LO] ==
                 second_source_register[`EMG_AM_HI:`EMG_BLK_LO];
   // address masking only narrows the compare, the masks use the same low bits
   wire same   = address_mask_bit ? same32 : same64;
   wire [MASK_W-1:0] merged = same ? (lmask & rmask) : lmask;

   // ----------------------------------------
   // flags from the subtraction
   // ----------------------------------------
   // carry is the borrow out, as a subtract setting flags reports it
   wire [DATA_W:0] diff   = {1'b0, first_source_register} -
                            {1'b0, second_source_register};
   wire [AM_W:0]   diff32 = {1'b0, first_source_register[`EMG_AM_HI:0]} -
                            {1'b0, second_source_register[`EMG_AM_HI:0]};
   wire v64 = (first_source_register[DATA_W-1] ^ second_source_register[DATA_W-1]) &
              (first_source_register[DATA_W-1] ^ diff[DATA_W-1]);
   wire v32 = (first_source_register[`EMG_AM_HI] ^ second_source_register[`EMG_AM_HI]) &
              (first_source_register[`EMG_AM_HI] ^ diff32[`EMG_AM_HI]);
   wire [CC_W-1:0] xcc_new = f_cc(diff[DATA_W-1],
                                  diff[DATA_W-1:0] == {DATA_W{1'b0}},
                                  v64,
                                  diff[DATA_W]);
   wire [CC_W-1:0] icc_new = f_cc(diff32[`EMG_AM_HI],
                                  diff32[`EMG_AM_HI:0] == {AM_W{1'b0}},
                                  v32,
                                  diff32[AM_W]);
   wire upd = issue_valid & flag_op;

   // ----------------------------------------
   // next values
   // ----------------------------------------
   reg              valid_next;
   reg              illegal_next;
   reg              ccw_next;
   reg [DATA_W-1:0] result_next;
   reg [CC_W-1:0]   icc_next;
   reg [CC_W-1:0]   xcc_next;

   always @* begin
      valid_next   = issue_valid & known;
      illegal_next = issue_valid & ~known;
      ccw_next     = upd;
      result_next  = result;
      icc_next     = icc;
      xcc_next     = xcc;
      if (valid_next) begin
         result_next = {{UPPER_W{1'b0}}, merged};
      end
      if (upd) begin
         icc_next = icc_new;
         xcc_next = xcc_new;
      end // no-flag variants hold icc and xcc
   end

   // ----------------------------------------
   // registered outputs
   // ----------------------------------------
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         result_valid <= 1'b0;
         result       <= {DATA_W{1'b0}};
         cc_write     <= 1'b0;
         icc          <= `EMG_RST_CC;
         xcc          <= `EMG_RST_CC;
         op_illegal   <= 1'b0;
      end else begin
         result_valid <= valid_next;
         op_illegal   <= illegal_next;
         cc_write     <= ccw_next;
         result       <= result_next;
         icc          <= icc_next;
         xcc          <= xcc_next;
      end
   end
endmodule

/* File: pkg/emg_map.vh */
`ifndef EMG_MAP_VH
`define EMG_MAP_VH
// ----------------------------------------
// operation select codes
// ----------------------------------------
`define EMG_OPF_W          9
`define EMG_OPF_LAST       9'h00B
`define EMG_OPF_NOFLAGS    0
`define EMG_OPF_LITTLE     1
`define EMG_OPF_SIZE_LO    2
`define EMG_OPF_SIZE_HI    3
`define EMG_SIZE_BYTE      2'h0
`define EMG_SIZE_HALF      2'h1
`define EMG_SIZE_WORD      2'h2
// ----------------------------------------
// operand fields
// ----------------------------------------
`define EMG_DATA_W         64
`define EMG_IDX_HI         2
`define EMG_IDX_W          3
`define EMG_CC_W           4
`define EMG_BLK_LO         3
`define EMG_AM_HI          31
`define EMG_MASK_W         8
`define EMG_FULL8          8'hFF
`define EMG_TOP8           8'h80
`define EMG_RST_CC         4'h0
// condition code bit positions inside a nibble: n z v c
`define EMG_CC_N           3
`define EMG_CC_Z           2
`define EMG_CC_V           1
`define EMG_CC_C           0
`endif

/* File: src/emg_mask_lut.v */
`timescale 1ns/1ps
`include "emg_map.vh"
// ----------------------------------------
// one edge mask, combinational
// ----------------------------------------
module emg_mask_lut (
   input  wire [1:0] size,
   input  wire       little,
   input  wire       right,
   input  wire [2:0] idx,
   output reg  [7:0] mask
);
   reg [7:0] be;
   integer   i;
   always @* begin
      be = 8'h00;
      case (size)
         // index plus one is widened so that index seven still fills the whole mask
         `EMG_SIZE_BYTE: be = right ? ~(`EMG_FULL8 >> ({1'b0, idx} + 4'h1))
                                    : (`EMG_FULL8 >> idx);
         `EMG_SIZE_HALF: be = right ? {4'h0, 4'hF & ~(4'hF >> ({1'b0, idx[2:1]} + 3'h1))}
                                    : {4'h0, 4'hF >> idx[2:1]};
         `EMG_SIZE_WORD: be = right ? {6'h00, 1'b1, idx[2]}
                                    : {6'h00, ~idx[2], 1'b1};
         default:        be = 8'h00;
      endcase
      mask = be;
      if (little) begin
         // reversal stays inside the element-count width
         for (i = 0; i < 8; i = i + 1) begin
            if (size == `EMG_SIZE_BYTE)
               mask[i] = be[7 - i];
            else if (size == `EMG_SIZE_HALF)
               mask[i] = (i < 4) ? be[3 - i] : 1'b0;
            else
               mask[i] = (i < 2) ? be[1 - i] : 1'b0;
         end
      end
   end
endmodule

/* File: tb/emg_edge_properties.sv */
`timescale 1ns/1ps
module emg_edge_properties (
   input wire        clk, resetn, issue_valid, result_valid, cc_write, op_illegal,
   input wire [8:0]  opf,
   input wire [63:0] result,
   input wire [3:0]  icc, xcc,
   input wire        address_mask_bit,
   input wire [63:0] first_source_register,
   input wire [63:0] second_source_register
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   wire legal = issue_valid && opf <= 9'h00B;
   a_valid_legal: assert property (
      legal |=> result_valid && !op_illegal) else $error("no result");
   a_illegal_flag: assert property (
      issue_valid && !legal |=> op_illegal && !result_valid && !cc_write) else $error("bad op");
   a_cc_write: assert property (
      legal && !opf[0] |=> cc_write) else $error("no flag write");
   a_noflag_hold: assert property (
      issue_valid && opf[0] |=> !cc_write && $stable(icc) && $stable(xcc)) else $error("flags");
   a_upper_zero: assert property (
      result_valid |-> result[63:8] == 56'h0) else $error("upper bits");
   a_half_width: assert property (
      legal && opf[3:2] == 2'h1 |=> result[63:4] == 60'h0) else $error("half width");
   a_word_width: assert property (
      legal && opf[3:2] == 2'h2 |=> result[63:2] == 62'h0) else $error("word width");
   a_result_hold: assert property (
      !legal |=> $stable(result)) else $error("result moved");
   a_equal_zero: assert property (
      legal && !opf[0] && first_source_register == second_source_register
      |=> icc[2] && xcc[2]) else $error("zero flag");
   a_left_alone: assert property (
      legal && !opf[1] && !address_mask_bit &&
      first_source_register[63:3] != second_source_register[63:3]
      |=> result[0]) else $error("left mask");
endmodule
bind emg_edge_unit emg_edge_properties i_chk (.*);

/* File: tb/emg_regfile_model.sv */
`timescale 1ns/1ps
// destination register and flag register as the pipeline writes them back
module emg_regfile_model (
   input wire         clk, result_valid, cc_write,
   input wire [63:0]  result,
   input wire [3:0]   icc, xcc,
   output logic [63:0] rd_q,
   output logic [7:0]  ccr_q
);
   always @(posedge clk) begin
      if (result_valid) rd_q <= result;
      if (cc_write) ccr_q <= {xcc, icc};
   end
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
   logic clk, resetn, iv, am, rv, cw, ill;
   logic [8:0] opf;
   logic [63:0] s1, s2, res, rd_q, erd;
   logic [3:0] icc, xcc;
   logic [7:0] ccr_q, ecc;
   integer err_total = 0, checked = 0, i, k;
   logic [128:0] rows [0:4] = '{{64'h1001, 64'h1006, 1'b0}, {64'h1003, 64'h2005, 1'b0},
      {64'hF000000000000002, 64'h7, 1'b1}, {64'hF000000000000002, 64'h7, 1'b0},
      {64'h5, 64'h5, 1'b0}};
   emg_edge_unit i_dut (.clk(clk), .resetn(resetn), .issue_valid(iv), .opf(opf),
      .address_mask_bit(am), .first_source_register(s1), .second_source_register(s2),
      .result_valid(rv), .result(res), .cc_write(cw), .icc(icc), .xcc(xcc), .op_illegal(ill));
   emg_regfile_model i_rf (.clk(clk), .result_valid(rv), .cc_write(cw), .result(res),
      .icc(icc), .xcc(xcc), .rd_q(rd_q), .ccr_q(ccr_q));
   initial begin clk = 0; forever #2 clk = ~clk; end
   // shifting both operands up by 32 gives the 32-bit flags from the same subtractor
   function [3:0] f_cc(input [63:0] a, b);
      reg [64:0] d;
      begin
         d = {1'b0, a} - {1'b0, b};
         f_cc = {d[63], d[63:0] == 64'h0, (a[63] ^ b[63]) & (d[63] ^ a[63]), d[64]};
      end
   endfunction
   function [7:0] f_mask(input [8:0] op, input [63:0] a, b, input m);
      integer w, j;
      reg [7:0] f, l, r, lr, rr;
      begin
         w = 8 >> op[3:2];
         f = 8'hFF >> (8 - w);
         l = f >> (a[2:0] >> op[3:2]);
         r = f & ~(f >> ((b[2:0] >> op[3:2]) + 1));
         lr = 8'h00;
         rr = 8'h00;
         for (j = 0; j < w; j++) begin lr[j] = l[w-1-j]; rr[j] = r[w-1-j]; end
         if (op[1]) begin l = lr; r = rr; end
         f_mask = (m ? a[31:3] == b[31:3] : a[63:3] == b[63:3]) ? l & r : l;
      end
   endfunction
   task chk(input [71:0] seen, exp);
      begin
         checked++;
         if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task run(input [8:0] op, input [63:0] a, b, input m);
      begin
         @(posedge clk);
         iv <= 1'b1; opf <= op; s1 <= a; s2 <= b; am <= m;
         @(posedge clk);
         iv <= 1'b0;
         #1;
         if (op <= 9'h00B) erd = f_mask(op, a, b, m);
         if (op <= 9'h00B && !op[0]) ecc = {f_cc(a, b), f_cc(a << 32, b << 32)};
         chk({rv, ill, cw}, {op <= 9'h00B, op > 9'h00B, op <= 9'h00B && !op[0]});
         chk(res, erd);
         chk({xcc, icc}, ecc);
         @(posedge clk);
         #1 chk({ccr_q, rd_q}, {ecc, erd});
      end
   endtask
   task report_and_stop;
      begin
         $display("checked %0d err_total %0d", checked, err_total);
         if (err_total == 0 && checked > 0) $display("verification passed");
         else $display("verification failed");
         $finish;
      end
   endtask
   initial begin #4000; err_total++; report_and_stop; end
   initial begin
      resetn = 0; iv = 0; opf = 0; am = 0; s1 = 0; s2 = 0; erd = 0; ecc = 0;
      repeat (10) @(posedge clk);
      #1 chk({rv, ill, cw, icc, xcc, res}, 72'h0);
      @(posedge clk) resetn <= 1'b1;
      for (k = 0; k < 12; k++) for (i = 0; i < 5; i++)
         run(k[8:0], rows[i][128:65], rows[i][64:1], rows[i][0]);
      run(9'h00C, 64'h1, 64'h2, 1'b0);
      run(9'h1FF, 64'h9, 64'h3, 1'b1);
      // reset again in mid-run: outputs clear, then a first issue is taken
      @(posedge clk) resetn <= 1'b0;
      #1 chk({rv, ill, cw, icc, xcc, res}, 72'h0);
      @(posedge clk) resetn <= 1'b1;
      run(9'h000, 64'h0, 64'h7, 1'b0);
      report_and_stop;
   end
endmodule
